// ### design/arps_ctrl.v
// reset and power-state controller of a dual-channel converter
// assumes Avalon-MM master on mclk; pins are asynchronous to mclk
//
// Notes on behaviour
// - a low pulse of at least 50 ns on the reset pin gives a full hardware reset
// - soft reset only when one write sets both reset bits
// - any hardware or soft reset sets the reset-seen flag
// - reset-seen clears only on a written 1; a 0 leaves it
// - power-on reset restores defaults and sets reset-seen
// - for 750 us after a pin or soft reset no conversions are taken; commands still are
// - operating mode 3 is shutdown, 0 is normal and default
// - reference settles 30 us after leaving shutdown; a pin or soft reset out of shutdown sets refReady with no wait
// - after each conversion drop back to standby by itself
// - one output format serves both channels
// - overrange and block-update flags are one bit each
// - each channel shifts on up to four lanes, one clock
// - host clock mode times bits internally; echo mode echoes clock
`timescale 1ns/1ps
`include "arps_consts.vh"
module arps_ctrl #(
  parameter HOLDOFF_CYC = `ARPS_HOLDOFF_CYC,
  parameter WORD        = 32
) (
  // clock and reset (rst_n is the supply-good power-on reset)
  input  wire        mclk,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // converter pins
  input  wire        hwRst_n,
  input  wire        convertStrobe,
  input  wire        sck,
  input  wire [WORD-1:0] ch0Sample,
  input  wire [WORD-1:0] ch1Sample,
  // outputs
  output reg  [3:0]  sdoCh0,
  output reg  [3:0]  sdoCh1,
  output reg         busySckOut,
  output reg         refReady,
  output reg         shutdown,
  output reg         convPower,
  output reg         lowVoltDrive,
  output reg         irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_SHDN = 2'h2;
  localparam HW_CYC  = `ARPS_RST_PW_CYC;
  localparam WAKE    = `ARPS_WAKE_CYC;
  localparam CONV_LD = `ARPS_CONV_CYC - 1;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] rstSync_r, cnvSync_r, sckSync_r;
  reg       cnvLast_r, sckLast_r;
  always @(posedge mclk) begin
    if (!rst_n) begin
      rstSync_r <= 2'h3;
      cnvSync_r <= 2'h0;
      sckSync_r <= 2'h0;
      cnvLast_r <= 1'b0;
      sckLast_r <= 1'b0;
    end else begin
      rstSync_r <= {rstSync_r[0], hwRst_n};
      cnvSync_r <= {cnvSync_r[0], convertStrobe};
      sckSync_r <= {sckSync_r[0], sck};
      cnvLast_r <= cnvSync_r[1];
      sckLast_r <= sckSync_r[1];
    end
  end
  wire cnvRise = cnvSync_r[1] & ~cnvLast_r;
  wire sckRise = sckSync_r[1] & ~sckLast_r;

  ////////////////////////////////////////////////////////////////////////
  // hardware reset pulse detector
  reg [3:0] lowCnt_r;
  reg       hwFire_r;
  always @(posedge mclk) begin
    if (!rst_n) begin
      lowCnt_r <= 4'h0;
      hwFire_r <= 1'b0;
    end else begin
      hwFire_r <= 1'b0;
      if (!rstSync_r[1]) begin
        if (lowCnt_r != 4'hF)
          lowCnt_r <= lowCnt_r + 4'h1;
      end else begin
        if (lowCnt_r >= HW_CYC[3:0])
          hwFire_r <= 1'b1;
        lowCnt_r <= 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  function [3:0] regIdx;
    input [5:0] a;
    begin
      regIdx = a[5:2];
    end
  endfunction

  wire       wrAcc = avs_write & ~avs_waitrequest;
  wire       rdAcc = avs_read & ~avs_waitrequest;
  wire [3:0] idx   = regIdx(avs_address);
  wire swFire = wrAcc && idx == `ARPS_OFF_IFCFG &&
                avs_writedata[`ARPS_SOFT_RESET_BIT] &&
                avs_writedata[`ARPS_SOFT_CONFIRM_BIT];
  wire anyRst = swFire | hwFire_r;

  ////////////////////////////////////////////////////////////////////////
  // configuration and hold-off
  reg [1:0]  opMode_r;
  reg        lowV_r;
  reg [7:0]  modes_r;
  reg        seen_r;
  reg [19:0] hold_r;
  reg [15:0] wake_r;
  reg [1:0]  st_r, st_nxt;
  reg [5:0]  convCnt_r;
  reg [2:0]  irqSt_r, irqEn_r;
  wire       holdOff = (hold_r != 20'h0);
  wire       shdnReq = (opMode_r == `ARPS_OPMODE_SHUTDOWN);

  always @(posedge mclk) begin
    if (!rst_n) begin
      opMode_r <= `ARPS_OPMODE_NORMAL;
      lowV_r   <= 1'b0;
      modes_r  <= `ARPS_MODES_RST;
      seen_r   <= 1'b1;
      hold_r   <= 20'h0;
      wake_r   <= 16'h0;
      irqEn_r  <= 3'h0;
    end else if (anyRst) begin
      opMode_r <= `ARPS_OPMODE_NORMAL;
      lowV_r   <= 1'b0;
      modes_r  <= `ARPS_MODES_RST;
      irqEn_r  <= 3'h0;
      seen_r   <= 1'b1;
      hold_r   <= HOLDOFF_CYC[19:0];
      wake_r   <= 16'h0;
    end else begin
      if (holdOff)
        hold_r <= hold_r - 20'h1;
      if (wrAcc && idx == `ARPS_OFF_DIAG &&
          avs_writedata[`ARPS_RESET_SEEN_BIT])
        seen_r <= 1'b0;
      if (wrAcc && idx == `ARPS_OFF_DEVCFG)
        opMode_r <= avs_writedata[`ARPS_OPMODE_HI:`ARPS_OPMODE_LO];
      if (wrAcc && idx == `ARPS_OFF_OUTDRV)
        lowV_r <= avs_writedata[`ARPS_LOWV_DRIVE_BIT];
      if (wrAcc && idx == `ARPS_OFF_MODES)
        modes_r <= avs_writedata[7:0];
      if (wrAcc && idx == `ARPS_OFF_IRQEN)
        irqEn_r <= avs_writedata[2:0];
      if (st_r == ST_SHDN && !shdnReq)
        wake_r <= WAKE[15:0];
      else if (wake_r != 16'h0)
        wake_r <= wake_r - 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state machine
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (shdnReq)
          st_nxt = ST_SHDN;
        else if (cnvRise && !holdOff)
          st_nxt = ST_CONV;
      end
      ST_CONV: begin
        if (convCnt_r == 6'h0)
          st_nxt = ST_IDLE;
      end
      ST_SHDN: begin
        if (!shdnReq)
          st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  wire convDone = (st_r == ST_CONV) && (convCnt_r == 6'h0);
  always @(posedge mclk) begin
    if (!rst_n || anyRst) begin
      st_r      <= ST_IDLE;
      convCnt_r <= 6'h0;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_IDLE && st_nxt == ST_CONV)
        convCnt_r <= CONV_LD[5:0];
      else if (convCnt_r != 6'h0)
        convCnt_r <= convCnt_r - 6'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample words and shifters
  // one-bit flags in the word
  function [WORD-1:0] fmtWord;
    input [WORD-1:0] s;
    input [7:0]      m;
    begin
      if (m[2:0] == 3'h3)
        fmtWord = s;
      else
        fmtWord = {s[WORD-1:2], 2'h0};
    end
  endfunction

  // host mode uses internal timing, echo uses sck
  wire hostClk  = modes_r[5:4] == 2'h2;
  wire shiftEn  = hostClk ? 1'b1 : sckRise;
  wire [7:0] sAll;
  wire [3:0] s0 = sAll[3:0];
  wire [3:0] s1 = sAll[7:4];
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gLane
      arps_lane_shift #(.WORD(WORD)) uShift (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .load    (convDone),
        .word    (fmtWord(g == 0 ? ch0Sample : ch1Sample, modes_r)),
        .shiftEn (shiftEn),
        .laneSel (modes_r[7:6]),
        .sdo_r   (sAll[4*g+3:4*g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // interrupts: reset done, conversion done, reference ready
  wire [2:0] ev = {wake_r == 16'h1, convDone, anyRst};
  always @(posedge mclk) begin
    if (!rst_n) begin
      irqSt_r <= 3'h0;
    end else if (wrAcc && idx == `ARPS_OFF_IRQCLR) begin
      // set wins over clear
      irqSt_r <= (irqSt_r & ~avs_writedata[2:0]) | ev;
    end else begin
      irqSt_r <= irqSt_r | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer and registered outputs
  reg [31:0] rd_nxt;
  always @* begin
    case (idx)
      `ARPS_OFF_IFCFG:   rd_nxt = 32'h0;
      `ARPS_OFF_DIAG:    rd_nxt = {31'h0, seen_r};
      `ARPS_OFF_DEVCFG:  rd_nxt = {30'h0, opMode_r};
      `ARPS_OFF_OUTDRV:  rd_nxt = {31'h0, lowV_r};
      `ARPS_OFF_MODES:   rd_nxt = {24'h0, modes_r};
      `ARPS_OFF_STATUS:  rd_nxt = {29'h0, holdOff, st_r};
      `ARPS_OFF_IRQSTAT: rd_nxt = {29'h0, irqSt_r};
      `ARPS_OFF_IRQEN:   rd_nxt = {29'h0, irqEn_r};
      default:           rd_nxt = 32'h0;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      sdoCh0 <= 4'h0;
      sdoCh1 <= 4'h0;
      busySckOut   <= 1'b0;
      refReady     <= 1'b1;
      shutdown     <= 1'b0;
      convPower    <= 1'b0;
      lowVoltDrive <= 1'b0;
      irq          <= 1'b0;
    end else begin
      // one wait cycle, then accept
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if ((avs_read | avs_write) & avs_waitrequest)
        avs_readdata <= avs_read ? rd_nxt : 32'h0;
      sdoCh0 <= s0;
      sdoCh1 <= s1;
      busySckOut   <= hostClk ? ~busySckOut :
                      (modes_r[5:4] == 2'h1 ? sckSync_r[1] :
                       st_r == ST_CONV);
      refReady     <= (st_r != ST_SHDN) && (wake_r == 16'h0);
      shutdown     <= st_r == ST_SHDN;
      convPower    <= st_r == ST_CONV;
      lowVoltDrive <= lowV_r;
      irq          <= |(irqSt_r & irqEn_r);
    end
  end
endmodule // arps_ctrl

// ### design/arps_lane_shift.v
// serial output shifter for one channel, one to four lanes
// assumes mclk domain; the link clock arrives already synchronised
`timescale 1ns/1ps
module arps_lane_shift #(
  parameter WORD = 32
) (
  // clock and reset
  input  wire            mclk,
  input  wire            rst_n,
  // control
  input  wire            load,
  input  wire [WORD-1:0] word,
  input  wire            shiftEn,
  input  wire [1:0]      laneSel,
  // lanes
  output reg  [3:0]      sdo_r
);
  reg [WORD-1:0] sh_r;
  reg [WORD-1:0] sh_nxt;
  reg [3:0]      sdo_nxt;

  always @* begin
    sh_nxt  = sh_r;
    sdo_nxt = sdo_r;
    if (load) begin
      sh_nxt = word;
    end else if (shiftEn) begin
      case (laneSel)
        2'h0: begin
          sdo_nxt = {3'h0, sh_r[WORD-1]};
          sh_nxt  = {sh_r[WORD-2:0], 1'h0};
        end
        2'h1: begin
          sdo_nxt = {2'h0, sh_r[WORD-1:WORD-2]};
          sh_nxt  = {sh_r[WORD-3:0], 2'h0};
        end
        default: begin
          sdo_nxt = sh_r[WORD-1:WORD-4];
          sh_nxt  = {sh_r[WORD-5:0], 4'h0};
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      sh_r  <= {WORD{1'b0}};
      sdo_r <= 4'h0;
    end else begin
      sh_r  <= sh_nxt;
      sdo_r <= sdo_nxt;
    end
  end
endmodule // arps_lane_shift

// ### dv/arps_ctrl_props.sv
// port checker for the reset and power-state controller
// assumes bind onto arps_ctrl, single mclk domain
`timescale 1ns/1ps
`include "arps_consts.vh"
module arps_ctrl_props #(
  parameter HOLDOFF_CYC = 50,
  parameter WORD        = 32
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_write,
  input wire logic        avs_read,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // pins
  input wire logic        hwRst_n,
  input wire logic        shutdown,
  input wire logic        refReady,
  input wire logic        convPower,
  input wire logic        lowVoltDrive
);
  localparam int WAKE = `ARPS_WAKE_CYC;
  reg  [15:0] wakeCnt_r;
  reg  [19:0] rstCnt_r;
  reg  [3:0]  lowCnt_r;
  wire        wrTaken = avs_write && !avs_waitrequest;
  wire        swRst   = wrTaken && avs_address[5:2] == 4'h0 &&
                        avs_writedata[0] && avs_writedata[7];
  ////////////////////////////////////////////////////////////////////////////
  // saturating counters: overflow would fake an early wake
  always @(posedge mclk) begin
    if (!rst_n) begin
      wakeCnt_r <= 16'hFFFF;
      rstCnt_r  <= 20'hFFFFF;
      lowCnt_r  <= 4'h0;
    end else begin
      wakeCnt_r <= shutdown ? 16'h0 : wakeCnt_r + {15'h0, ~&wakeCnt_r};
      rstCnt_r  <= (!hwRst_n || swRst) ? 20'h0 :
                   rstCnt_r + {19'h0, ~&rstCnt_r};
      lowCnt_r  <= hwRst_n ? 4'h0 : lowCnt_r + {3'h0, ~&lowCnt_r};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no bus answer");
  property p_shut_on;
    wrTaken && avs_address[5:2] == 4'h2 && avs_writedata[1:0] == 2'h3
      |-> ##[3:32] shutdown;
  endproperty
  a_shut_on: assert property (p_shut_on) else $error("no shutdown");
  property p_wake_gap;
    $rose(refReady) |-> wakeCnt_r >= WAKE - 2;
  endproperty
  a_wake_gap: assert property (p_wake_gap) else $error("early ready");
  property p_ref_off;
    shutdown |-> !refReady;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("ready in shutdown");
  property p_conv_len;
    $rose(convPower) |-> convPower [*8] ##[1:30] !convPower;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("bad conv length");
  property p_holdoff;
    $rose(convPower) |-> rstCnt_r >= HOLDOFF_CYC;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("conv in hold-off");
  property p_hw_rst;
    $rose(hwRst_n) && lowCnt_r >= 4'h5 |-> ##[1:10] !lowVoltDrive && !shutdown;
  endproperty
  a_hw_rst: assert property (p_hw_rst) else $error("pin reset lost");
  c_conv: cover property ($rose(convPower));
  c_shut: cover property ($rose(shutdown));
  c_pin:  cover property ($rose(hwRst_n));
  c_wake: cover property ($rose(refReady));
endmodule // arps_ctrl_props
bind arps_ctrl arps_ctrl_props #(.HOLDOFF_CYC(HOLDOFF_CYC), .WORD(WORD))
  i_arps_ctrl_props (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_write(avs_write), .avs_read(avs_read), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .hwRst_n(hwRst_n), .shutdown(shutdown),
  .refReady(refReady), .convPower(convPower), .lowVoltDrive(lowVoltDrive));

// ### dv/arps_ctrl_tb_top.sv
// self-checking bench for the reset and power-state controller
// assumes arps_ctrl, arps_host_model and the bound checker
`timescale 1ns/1ps
`include "arps_consts.vh"
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module arps_ctrl_tb_top;
  localparam HOLD = 50;
  logic        mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic        rstReq = 0, cnvReq = 0, sckRun = 0, convSeen = 0, b;
  logic [5:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, ch0Sample = 0, ch1Sample = 0, q, n;
  logic [31:0] seed = 32'h1285ED3A;
  wire  [31:0] avs_readdata;
  wire  [3:0]  sdoCh0, sdoCh1;
  wire         avs_waitrequest, hwRst_n, convertStrobe, sck, busySckOut;
  wire         refReady, shutdown, convPower, lowVoltDrive, irq;
  int          mismatches = 0, cmp_count = 0, t;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (convPower === 1'b1) convSeen <= 1'b1;
  arps_ctrl #(.HOLDOFF_CYC(HOLD)) i_arps_ctrl (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hwRst_n(hwRst_n),
    .convertStrobe(convertStrobe), .sck(sck), .ch0Sample(ch0Sample),
    .ch1Sample(ch1Sample), .sdoCh0(sdoCh0), .sdoCh1(sdoCh1),
    .busySckOut(busySckOut), .refReady(refReady), .shutdown(shutdown),
    .convPower(convPower), .lowVoltDrive(lowVoltDrive), .irq(irq));
  arps_host_model i_arps_host_model (.mclk(mclk), .rstReq(rstReq),
    .cnvReq(cnvReq), .sckRun(sckRun), .hwRst_n(hwRst_n),
    .convertStrobe(convertStrobe), .sck(sck));
  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [7:0] modesVal(logic [31:0] r);
    return {r[7:6], 2'b01, 1'b0, r[2:0]};
  endfunction
  task bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // no cycle count assumed: only the watchdog ends a hung access
    do @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge mclk);
  endtask
  task pulse(input logic r);
    if (r) rstReq <= 1; else cnvReq <= 1;
    @(posedge mclk);
    rstReq <= 0;
    cnvReq <= 0;
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    bus(0, 1, 0); `CHK(q[0], 1'b1)
    bus(0, 2, 0); `CHK(q[1:0], `ARPS_OPMODE_NORMAL)
    bus(0, 4, 0); `CHK(q[7:0], `ARPS_MODES_RST)
    bus(0, 15, 0); `CHK(q, 32'h0)
    bus(1, 1, 0); bus(0, 1, 0); `CHK(q[0], 1'b1)
    bus(1, 1, 1); bus(0, 1, 0); `CHK(q[0], 1'b0)
    $display("reset values and flag clear done");
    n = rnd();
    bus(1, 3, n); @(posedge mclk); `CHK(lowVoltDrive, n[0])
    bus(1, 0, 32'h1); bus(1, 0, 32'h80);
    bus(0, 1, 0); `CHK(q[0], 1'b0)
    bus(1, 0, 32'h81); bus(0, 1, 0); `CHK(q[0], 1'b1)
    bus(0, 0, 0); `CHK(q[7:0], 8'h00)
    repeat (HOLD + 10) @(posedge mclk);
    $display("soft reset done");
    bus(1, 1, 1); bus(1, 3, 1);
    // explicit pin reset; settle time shortened
    pulse(1);
    repeat (15) @(posedge mclk);
    bus(0, 1, 0); `CHK(q[0], 1'b1)
    `CHK(lowVoltDrive, 1'b0)
    convSeen <= 0;
    pulse(0);
    repeat (10) @(posedge mclk);
    `CHK(convSeen, 1'b0)
    repeat (HOLD) @(posedge mclk);
    $display("pin reset done");
    bus(1, 7, 2);
    ch0Sample <= rnd();
    ch1Sample <= rnd();
    convSeen <= 0;
    pulse(0);
    repeat (10) @(posedge mclk);
    `CHK(convSeen, 1'b1)
    repeat (40) @(posedge mclk);
    `CHK(convPower, 1'b0)
    `CHK(irq, 1'b1)
    bus(0, 6, 0); `CHK(q[1], 1'b1)
    bus(1, 7, 0); @(posedge mclk); `CHK(irq, 1'b0)
    bus(1, 7, 2); bus(1, 8, 2); @(posedge mclk); `CHK(irq, 1'b0)
    bus(0, 6, 0); `CHK(q[1], 1'b0)
    $display("conversion and interrupt done");
    bus(1, 2, 3); repeat (2) @(posedge mclk);
    `CHK(shutdown, 1'b1)
    `CHK(refReady, 1'b0)
    bus(1, 2, 0);
    t = 0;
    while (refReady !== 1'b1 && t < 4000) begin
      @(posedge mclk);
      t++;
    end
    `CHK(t >= `ARPS_WAKE_CYC - 10 && t < 4000, 1'b1)
    $display("shutdown and wake done");
    // host clock mode shifts every cycle, four lanes, raw format
    bus(1, 4, 32'hA3);
    ch0Sample <= rnd();
    ch1Sample <= rnd();
    pulse(0);
    while (convPower !== 1'b1) @(posedge mclk);
    while (convPower !== 1'b0) @(posedge mclk);
    @(posedge mclk);
    `CHK(sdoCh0, ch0Sample[31:28])
    `CHK(sdoCh1, ch1Sample[31:28])
    @(posedge mclk);
    `CHK(sdoCh0, ch0Sample[27:24])
    `CHK(sdoCh1, ch1Sample[27:24])
    $display("host clock lanes done");
    n = rnd();
    bus(1, 4, {24'h0, modesVal(n)});
    bus(0, 4, 0); `CHK(q[7:0], modesVal(n))
    sckRun <= 1;
    b = busySckOut;
    t = 0;
    repeat (100) begin
      @(posedge mclk);
      if (busySckOut !== b) t++;
      b = busySckOut;
    end
    `CHK(t >= 20 && t <= 30, 1'b1)
    sckRun <= 0;
    $display("echo clock done");
    summarize();
  end
  initial begin
    #200000;
    mismatches++;
    $display("MISMATCH t=%0t watchdog", $time);
    summarize();
  end
endmodule // arps_ctrl_tb_top

// ### dv/arps_host_model.sv
// host side: reset pin, convert strobe and gated serial clock
// assumes the bench pulses rstReq and cnvReq for one cycle; sckRun is held as a level
`timescale 1ns/1ps
module arps_host_model #(
  parameter RST_LOW = 6
) (
  // requests
  input  wire logic mclk,
  input  wire logic rstReq,
  input  wire logic cnvReq,
  input  wire logic sckRun,
  // pins
  output logic      hwRst_n,
  output logic      convertStrobe,
  output logic      sck
);
  logic [3:0] lowCnt_r = 4'h0;
  logic [3:0] cnvCnt_r = 4'h0;
  initial begin
    hwRst_n = 1'b1;
    convertStrobe = 1'b0;
    sck = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // pulse width: 6 cycles, above 50 ns
  always @(posedge mclk) begin
    lowCnt_r <= rstReq ? RST_LOW : lowCnt_r - {3'h0, |lowCnt_r};
    hwRst_n  <= !(rstReq || lowCnt_r > 4'h1);
    cnvCnt_r <= cnvReq ? 4'h4 : cnvCnt_r - {3'h0, |cnvCnt_r};
    convertStrobe <= cnvReq || cnvCnt_r > 4'h1;
  end
  // 80 ns link clock, still outside frames
  always begin
    #40;
    sck <= sckRun ? ~sck : 1'b0;
  end
endmodule // arps_host_model

// ### include/arps_consts.vh
// constants for the converter reset and power-state controller
// assumes a 100 MHz mclk; included by bare name
`ifndef ARPS_CONSTS_VH
`define ARPS_CONSTS_VH

// register word indices (address bits 5:2)
`define ARPS_OFF_IFCFG    4'h0
`define ARPS_OFF_DIAG     4'h1
`define ARPS_OFF_DEVCFG   4'h2
`define ARPS_OFF_OUTDRV   4'h3
`define ARPS_OFF_MODES    4'h4
`define ARPS_OFF_STATUS   4'h5
`define ARPS_OFF_IRQSTAT  4'h6
`define ARPS_OFF_IRQEN    4'h7
`define ARPS_OFF_IRQCLR   4'h8
`define ARPS_OFF_SAMPLE   4'h9

// field positions
`define ARPS_SOFT_RESET_BIT   0
`define ARPS_SOFT_CONFIRM_BIT 7
`define ARPS_RESET_SEEN_BIT   0
`define ARPS_LOWV_DRIVE_BIT   0
`define ARPS_OPMODE_LO        0
`define ARPS_OPMODE_HI        1

// reset values and encodings
`define ARPS_OPMODE_NORMAL    2'h0
`define ARPS_OPMODE_SHUTDOWN  2'h3
`define ARPS_MODES_RST        8'h00

// timing
`define ARPS_CLK_MHZ          100
`define ARPS_RST_PW_NS        50
`define ARPS_RST_PW_CYC       ((`ARPS_RST_PW_NS*`ARPS_CLK_MHZ+999)/1000)
`define ARPS_HOLDOFF_US       750
`define ARPS_HOLDOFF_CYC      (`ARPS_HOLDOFF_US*`ARPS_CLK_MHZ)
`define ARPS_WAKE_US          30
`define ARPS_WAKE_CYC         (`ARPS_WAKE_US*`ARPS_CLK_MHZ)
`define ARPS_CONV_CYC         28

`endif
